// >>> ioxs_filter.sv

package ioxs_pkg;
  // ==========================================================
  // Timing
  localparam int LINK_NS = 80;
  localparam int SPIKE_NS = 50;
  localparam int TIMEOUT_MS = 25;
  localparam int SPIKE_CYCLES_I = (SPIKE_NS + LINK_NS - 1) / LINK_NS;
  localparam int TIMEOUT_CYCLES_DEF = TIMEOUT_MS * 1000000 / LINK_NS;
  localparam int FILT_W = 3;
  localparam int TO_W = 24;
  // ==========================================================
  // Geometry and pointer layout
  localparam int NUM_BANKS = 5;
  localparam int NUM_IO = 40;
  localparam int BANK_W = 3;
  localparam int CAT_LSB = 3;
  localparam int AI_BIT = 7;
  localparam logic [2:0] LAST_BANK = 3'h4;
  localparam logic [2:0] CAT_IP = 3'h0;
  localparam logic [2:0] CAT_OP = 3'h1;
  localparam logic [2:0] CAT_PI = 3'h2;
  localparam logic [2:0] CAT_IOC = 3'h3;
  localparam logic [2:0] CAT_MSK = 3'h4;
  // ==========================================================
  // Reset values and addressing
  localparam logic [7:0] OP_RST = 8'h00;
  localparam logic [7:0] PI_RST = 8'h00;
  localparam logic [7:0] IOC_RST = 8'hff;
  localparam logic [7:0] MSK_RST = 8'hff;
  localparam logic [3:0] SLAVE_BASE = 4'h4;
  localparam logic [2:0] LAST_BIT = 3'h7;

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_ADDR_ACK, S_CMD, S_CMD_ACK, S_WDATA, S_WDATA_ACK, S_RDATA, S_RACK
  } ioxs_state_e;
endpackage : ioxs_pkg

module ioxs_filter (
  // Clock and reset
  input wire logic link_clk,
  input wire logic reset,
  // Raw line and clean level
  input wire logic pin,
  output logic level
);
  import ioxs_pkg::*;
  localparam logic [FILT_W-1:0] SPIKE_CYCLES = FILT_W'(SPIKE_CYCLES_I);
  logic meta;
  logic sync;
  logic [FILT_W-1:0] cnt;
  wire differs = (sync != level);

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      meta <= 1'b1;
      sync <= 1'b1;
      level <= 1'b1;
      cnt <= '0;
    end else begin
      meta <= pin;
      sync <= meta;
      if (!differs) begin
        cnt <= '0;
      end else if (cnt == SPIKE_CYCLES) begin
        level <= sync;
        cnt <= '0;
      end else begin
        cnt <= cnt + 1'b1;
      end
    end
  end

  // A new level must have been seen on two samples in a row
  a_spike_reject: assert property (@(posedge link_clk) disable iff (reset)
    $changed(level) |-> ($past(sync) == level) && ($past(sync, 2) == level))
    else $error("Filtered level changed after a single sample");
endmodule : ioxs_filter

// >>> ioxs_slave.sv
module ioxs_slave #(
  parameter int TIMEOUT_CYCLES = ioxs_pkg::TIMEOUT_CYCLES_DEF
) (
  // System clock domain
  input wire logic clk,
  input wire logic reset,
  // Link clock domain
  input wire logic link_clk,
  // Serial bus lines
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // Static straps and controls
  input wire logic [2:0] addr_sel,
  input wire logic timeout_en,
  input wire logic out_en_n,
  // Port pins
  input wire logic [ioxs_pkg::NUM_IO-1:0] io_in,
  output logic [ioxs_pkg::NUM_IO-1:0] io_out,
  output logic [ioxs_pkg::NUM_IO-1:0] io_oe,
  // Interrupt pin, open drain
  output logic irq_out,
  output logic irq_oe
);
  import ioxs_pkg::*;

  localparam logic [TO_W-1:0] TO_LAST = TO_W'(TIMEOUT_CYCLES - 1);

  function automatic logic [5:0] inc_ptr(input logic [5:0] p);
    inc_ptr = (p[BANK_W-1:0] >= LAST_BANK) ? {p[5:CAT_LSB], 3'h0} : p + 6'h01;
  endfunction : inc_ptr

  function automatic logic bank_ok(input logic [5:0] p);
    bank_ok = (p[BANK_W-1:0] <= LAST_BANK);
  endfunction : bank_ok

  // ==========================================================
  // Line filtering (link domain)
  logic scl_f;
  logic sda_f;
  logic scl_d;
  logic sda_d;
  logic [2:0] addr_m;
  logic [2:0] addr_s;
  // Time-out enable is a static pin, but still crosses into the link domain
  logic to_en_m;
  logic to_en_s;

  ioxs_filter u_scl_filt (
    .link_clk(link_clk),
    .reset(reset),
    .pin(scl_in),
    .level(scl_f)
  );

  ioxs_filter u_sda_filt (
    .link_clk(link_clk),
    .reset(reset),
    .pin(sda_in),
    .level(sda_f)
  );

  wire scl_rise = scl_f & ~scl_d;
  wire scl_fall = ~scl_f & scl_d;
  wire start_det = scl_f & scl_d & sda_d & ~sda_f;
  wire stop_det = scl_f & scl_d & ~sda_d & sda_f;
  wire [6:0] dev_addr = {SLAVE_BASE, addr_s};

  // ==========================================================
  // Stuck-bus time-out
  logic [TO_W-1:0] to_cnt;
  wire bus_low = ~scl_f | ~sda_f;
  wire to_hit = to_en_s & bus_low & (to_cnt == TO_LAST);

  // ==========================================================
  // Serial engine state
  ioxs_state_e state;
  ioxs_state_e next_state;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] tx;
  logic [7:0] next_tx;
  logic [2:0] bit_cnt;
  logic [2:0] next_bit_cnt;
  logic done;
  logic next_done;
  logic next_oe;
  logic rw;
  logic next_rw;
  logic ai;
  logic next_ai;
  logic [5:0] ptr;
  logic [5:0] next_ptr;
  logic [5:0] wr_addr;
  logic [5:0] next_wr_addr;
  logic [7:0] wr_data;
  logic [7:0] next_wr_data;
  logic wr_tgl;
  logic next_wr_tgl;
  logic [5:0] rd_addr;
  logic [5:0] next_rd_addr;
  logic rd_tgl;
  logic next_rd_tgl;
  logic [7:0] rd_byte;
  logic [2:0] rd_ack_s;
  logic [7:0] rd_data;
  logic rd_ack_tgl;

  wire rx_state = (state == S_ADDR) || (state == S_CMD) || (state == S_WDATA);
  wire rd_ack_edge = rd_ack_s[2] ^ rd_ack_s[1];
  wire [7:0] rd_now = rd_ack_edge ? rd_data : rd_byte;

  always_comb begin
    next_state = state;
    next_shreg = shreg;
    next_tx = tx;
    next_bit_cnt = bit_cnt;
    next_done = done;
    next_oe = sda_oe;
    next_rw = rw;
    next_ai = ai;
    next_ptr = ptr;
    next_wr_addr = wr_addr;
    next_wr_data = wr_data;
    next_wr_tgl = wr_tgl;
    next_rd_addr = rd_addr;
    next_rd_tgl = rd_tgl;
    if (to_hit || stop_det) begin
      next_state = S_IDLE;
      next_oe = 1'b0;
      next_done = 1'b0;
    end else if (start_det) begin
      next_state = S_ADDR;
      next_bit_cnt = '0;
      next_done = 1'b0;
      next_oe = 1'b0;
    end else begin
      case (state)
        S_IDLE: begin
          next_oe = 1'b0;
        end
        S_ADDR, S_CMD, S_WDATA: begin
          if (scl_rise) begin
            next_shreg = {shreg[6:0], sda_f};
            next_bit_cnt = bit_cnt + 1'b1;
            next_done = (bit_cnt == LAST_BIT);
          end else if (scl_fall && done) begin
            next_done = 1'b0;
            next_oe = 1'b1;
            if (state == S_ADDR) begin
              if (shreg[7:1] == dev_addr) begin
                next_rw = shreg[0];
                next_state = S_ADDR_ACK;
                if (shreg[0]) begin
                  next_rd_addr = ptr;
                  next_rd_tgl = ~rd_tgl;
                end
              end else begin
                next_oe = 1'b0;
                next_state = S_IDLE;
              end
            end else if (state == S_CMD) begin
              next_ptr = shreg[5:0];
              next_ai = shreg[AI_BIT];
              next_state = S_CMD_ACK;
            end else begin
              next_wr_addr = ptr;
              next_wr_data = shreg;
              next_wr_tgl = ~wr_tgl;
              next_ptr = ai ? inc_ptr(ptr) : ptr;
              next_state = S_WDATA_ACK;
            end
          end
        end
        S_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw) begin
              next_state = S_RDATA;
              next_oe = ~rd_now[7];
              next_tx = {rd_now[6:0], 1'b0};
              next_bit_cnt = 3'h1;
            end else begin
              next_state = S_CMD;
              next_oe = 1'b0;
              next_bit_cnt = '0;
            end
          end
        end
        S_CMD_ACK, S_WDATA_ACK: begin
          if (scl_fall) begin
            next_state = S_WDATA;
            next_oe = 1'b0;
            next_bit_cnt = '0;
          end
        end
        S_RDATA: begin
          if (scl_fall) begin
            if (bit_cnt == '0) begin
              next_state = S_RACK;
              next_oe = 1'b0;
            end else begin
              next_oe = ~tx[7];
              next_tx = {tx[6:0], 1'b0};
              next_bit_cnt = bit_cnt + 1'b1;
            end
          end
        end
        S_RACK: begin
          if (scl_rise) begin
            if (!sda_f) begin
              next_ptr = ai ? inc_ptr(ptr) : ptr;
              next_rd_addr = ai ? inc_ptr(ptr) : ptr;
              next_rd_tgl = ~rd_tgl;
              next_done = 1'b1;
            end else begin
              next_state = S_IDLE;
            end
          end else if (scl_fall && done) begin
            next_done = 1'b0;
            next_state = S_RDATA;
            next_oe = ~rd_now[7];
            next_tx = {rd_now[6:0], 1'b0};
            next_bit_cnt = 3'h1;
          end
        end
        default: begin
          next_state = S_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      addr_m <= '0;
      addr_s <= '0;
      to_cnt <= '0;
      to_en_m <= 1'b0;
      to_en_s <= 1'b0;
      rd_ack_s <= '0;
      rd_byte <= '0;
    end else begin
      scl_d <= scl_f;
      sda_d <= sda_f;
      addr_m <= addr_sel;
      addr_s <= addr_m;
      to_en_m <= timeout_en;
      to_en_s <= to_en_m;
      to_cnt <= (bus_low && to_en_s && !to_hit) ? to_cnt + 1'b1 : '0;
      rd_ack_s <= {rd_ack_s[1:0], rd_ack_tgl};
      rd_byte <= rd_now;
    end
  end

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      state <= S_IDLE;
      shreg <= '0;
      tx <= '0;
      bit_cnt <= '0;
      done <= 1'b0;
      sda_oe <= 1'b0;
      sda_out <= 1'b0;
      rw <= 1'b0;
      ai <= 1'b0;
      ptr <= '0;
    end else begin
      state <= next_state;
      shreg <= next_shreg;
      tx <= next_tx;
      bit_cnt <= next_bit_cnt;
      done <= next_done;
      sda_oe <= next_oe;
      sda_out <= 1'b0;
      rw <= next_rw;
      ai <= next_ai;
      ptr <= next_ptr;
    end
  end

  always_ff @(posedge link_clk or posedge reset) begin
    if (reset) begin
      wr_addr <= '0;
      wr_data <= '0;
      wr_tgl <= 1'b0;
      rd_addr <= '0;
      rd_tgl <= 1'b0;
    end else begin
      wr_addr <= next_wr_addr;
      wr_data <= next_wr_data;
      wr_tgl <= next_wr_tgl;
      rd_addr <= next_rd_addr;
      rd_tgl <= next_rd_tgl;
    end
  end

  // ==========================================================
  // Register file and port logic (system domain)
  logic [7:0] op_reg [0:NUM_BANKS-1];
  logic [7:0] pi_reg [0:NUM_BANKS-1];
  logic [7:0] ioc_reg [0:NUM_BANKS-1];
  logic [7:0] msk_reg [0:NUM_BANKS-1];
  logic [7:0] snap [0:NUM_BANKS-1];
  logic [7:0] in_bank [0:NUM_BANKS-1];
  logic [NUM_IO-1:0] in_m;
  logic [NUM_IO-1:0] in_s;
  logic oe_m;
  logic oe_s;
  logic [2:0] wr_s;
  logic [2:0] rd_s;
  logic [NUM_BANKS-1:0] changed;
  logic [7:0] rd_mux;
  logic [NUM_IO-1:0] next_io_oe;
  logic [NUM_IO-1:0] next_io_out;

  wire wr_edge = wr_s[2] ^ wr_s[1];
  wire rd_edge = rd_s[2] ^ rd_s[1];
  wire [2:0] wr_cat = wr_addr[5:CAT_LSB];
  wire [2:0] wr_bank = wr_addr[BANK_W-1:0];
  wire [2:0] rd_cat = rd_addr[5:CAT_LSB];
  wire [2:0] rd_bank = rd_addr[BANK_W-1:0];

  always_comb begin
    rd_mux = 8'h00;
    for (int b = 0; b < NUM_BANKS; b++) begin
      in_bank[b] = in_s[b*8 +: 8];
      changed[b] = |((in_bank[b] ^ snap[b]) & ioc_reg[b] & ~msk_reg[b]);
      next_io_out[b*8 +: 8] = op_reg[b];
      next_io_oe[b*8 +: 8] = ~ioc_reg[b] & {8{~oe_s}};
    end
    if (!bank_ok(rd_addr)) begin
      rd_mux = 8'h00;
    end else if (rd_cat == CAT_IP) begin
      rd_mux = in_bank[rd_bank] ^ pi_reg[rd_bank];
    end else if (rd_cat == CAT_OP) begin
      rd_mux = op_reg[rd_bank];
    end else if (rd_cat == CAT_PI) begin
      rd_mux = pi_reg[rd_bank];
    end else if (rd_cat == CAT_IOC) begin
      rd_mux = ioc_reg[rd_bank];
    end else if (rd_cat == CAT_MSK) begin
      rd_mux = msk_reg[rd_bank];
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      in_m <= '0;
      in_s <= '0;
      oe_m <= 1'b1;
      oe_s <= 1'b1;
      wr_s <= '0;
      rd_s <= '0;
      io_out <= '0;
      io_oe <= '0;
      irq_out <= 1'b0;
      irq_oe <= 1'b0;
    end else begin
      in_m <= io_in;
      in_s <= in_m;
      oe_m <= out_en_n;
      oe_s <= oe_m;
      wr_s <= {wr_s[1:0], wr_tgl};
      rd_s <= {rd_s[1:0], rd_tgl};
      io_out <= next_io_out;
      io_oe <= next_io_oe;
      irq_out <= 1'b0;
      irq_oe <= |changed;
    end
  end

  // Snapshot is taken when an input bank is read, so the pending change of that bank clears
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int b = 0; b < NUM_BANKS; b++) begin
        op_reg[b] <= OP_RST;
        pi_reg[b] <= PI_RST;
        ioc_reg[b] <= IOC_RST;
        msk_reg[b] <= MSK_RST;
        snap[b] <= 8'h00;
      end
      rd_data <= '0;
      rd_ack_tgl <= 1'b0;
    end else begin
      if (wr_edge && bank_ok(wr_addr)) begin
        if (wr_cat == CAT_OP) op_reg[wr_bank] <= wr_data;
        if (wr_cat == CAT_PI) pi_reg[wr_bank] <= wr_data;
        if (wr_cat == CAT_IOC) ioc_reg[wr_bank] <= wr_data;
        if (wr_cat == CAT_MSK) msk_reg[wr_bank] <= wr_data;
      end
      if (rd_edge) begin
        rd_data <= rd_mux;
        rd_ack_tgl <= ~rd_ack_tgl;
        if (rd_cat == CAT_IP && bank_ok(rd_addr)) snap[rd_bank] <= in_bank[rd_bank];
      end
    end
  end

  // ==========================================================
  // Checks
  sequence s_byte_end;
    scl_fall && done && (state == S_CMD || state == S_WDATA);
  endsequence

  sequence s_ack_slot;
    sda_oe [*1] ##1 (sda_oe || state == S_WDATA);
  endsequence

  a_ack_drive: assert property (@(posedge link_clk) disable iff (reset)
    s_byte_end |=> s_ack_slot)
    else $error("Received byte not acknowledged");

  a_idle_silent: assert property (@(posedge link_clk) disable iff (reset)
    state == S_IDLE |-> !sda_oe)
    else $error("Data line driven while idle");

  a_stop_idle: assert property (@(posedge link_clk) disable iff (reset)
    stop_det |=> state == S_IDLE && !sda_oe)
    else $error("Stop did not end the transfer");

  a_start_addr: assert property (@(posedge link_clk) disable iff (reset)
    start_det && !to_hit |=> state == S_ADDR && bit_cnt == 3'h0)
    else $error("Start did not begin address matching");

  a_stable_high: assert property (@(posedge link_clk) disable iff (reset)
    scl_f && scl_d && !start_det |=> $stable(sda_oe) || !scl_f)
    else $error("Data line changed while clock high");

  a_rack_release: assert property (@(posedge link_clk) disable iff (reset)
    state == S_RACK |-> !sda_oe)
    else $error("Data line held during master acknowledge");

  a_bit_count: assert property (@(posedge link_clk) disable iff (reset)
    scl_rise && rx_state && !start_det && !stop_det && !to_hit
      |=> bit_cnt == 3'($past(bit_cnt) + 3'h1))
    else $error("Bit not counted on clock rise");

  a_ptr_hold: assert property (@(posedge link_clk) disable iff (reset)
    state == S_RACK && scl_rise && !sda_f && !ai && !to_hit && !stop_det && !start_det
      |=> ptr == $past(ptr))
    else $error("Pointer moved without auto-increment");

  a_ptr_wrap: assert property (@(posedge link_clk) disable iff (reset)
    state == S_RACK && scl_rise && !sda_f && ai && ptr[BANK_W-1:0] == LAST_BANK
      && !to_hit && !stop_det && !start_det |=> ptr[BANK_W-1:0] == 3'h0
      && ptr[5:CAT_LSB] == $past(ptr[5:CAT_LSB]))
    else $error("Pointer did not wrap within category");

  a_nack_release: assert property (@(posedge link_clk) disable iff (reset)
    state == S_RACK && scl_rise && sda_f |=> state == S_IDLE ##1 !sda_oe)
    else $error("Data line not released after missing acknowledge");

  a_timeout: assert property (@(posedge link_clk) disable iff (reset)
    to_hit |=> state == S_IDLE && to_cnt == '0)
    else $error("Time-out did not reset the engine");

  a_irq_track: assert property (@(posedge clk) disable iff (reset)
    ##1 (irq_oe == $past(|changed)))
    else $error("Interrupt does not follow pending changes");

  a_irq_read: assert property (@(posedge clk) disable iff (reset)
    rd_edge && rd_cat == CAT_IP && bank_ok(rd_addr) |=> !changed[$past(rd_bank)]
      || $changed(in_s))
    else $error("Input bank read did not clear its change");
endmodule : ioxs_slave

// >>> ioxs_master.sv
module ioxs_master (
  // Bus lines
  input wire logic sda,
  output logic scl,
  output logic sda_low
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================
  // Bit timing: 600 ns low and 600 ns high
  localparam int Q = 300;
  logic glitch;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    glitch = 1'b0;
  end

  // Also serves as repeated start from a low clock
  // Waits half a bit before raising the clock so a slave still holding its ack has let go
  task automatic start();
    #Q sda_low = 1'b0;
    #Q scl = 1'b1;
    #Q sda_low = 1'b1;
    #Q scl = 1'b0;
  endtask : start

  task automatic stop();
    #Q sda_low = 1'b1;
    #Q scl = 1'b1;
    #Q sda_low = 1'b0;
    #Q;
  endtask : stop

  // Data only moves in the low phase; optional 40 ns dip tests the filter
  task automatic bit_io(input logic b, output logic r);
    #Q sda_low = ~b;
    #Q scl = 1'b1;
    if (glitch && b) begin
      #100 sda_low = 1'b1;
      #40 sda_low = 1'b0;
      #(Q - 140) r = sda;
    end else begin
      #Q r = sda;
    end
    #Q scl = 1'b0;
  endtask : bit_io

  // Released data bits read the slave; mack 1 releases the ack slot
  task automatic xfer(input logic [7:0] d, input logic mack, output logic [7:0] q,
                      output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(mack, ack);
  endtask : xfer
endmodule : ioxs_master

// >>> test_i2c_slave_register_access.sv
module test_i2c_slave_register_access;
  timeunit 1ns;
  timeprecision 1ps;
  import ioxs_pkg::*;
  localparam logic [2:0] strap = 3'h5;
  localparam logic [6:0] dev_addr = {SLAVE_BASE, strap};
  logic clk, reset, link_clk, scl, sda, m_low, sda_out, sda_oe;
  logic timeout_en, out_en_n, irq_out, irq_oe;
  logic [NUM_IO-1:0] io_in, io_out, io_oe;
  int n_mismatch, checks_done;

  // Open drain: low if either party pulls
  assign sda = ~((sda_oe & ~sda_out) | m_low);

  ioxs_slave #(.TIMEOUT_CYCLES(200)) i_ioxs_slave (
    .clk(clk), .reset(reset), .link_clk(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(strap), .timeout_en(timeout_en),
    .out_en_n(out_en_n), .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .irq_out(irq_out), .irq_oe(irq_oe));

  ioxs_master i_ioxs_master (.sda(sda), .scl(scl), .sda_low(m_low));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    link_clk = 1'b0;
    #13;
    forever #40 link_clk = ~link_clk;
  end

  // ==========================================================
  // Helpers
  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] cmd, input logic [7:0] d[$]);
    logic [7:0] q;
    logic a;
    i_ioxs_master.start();
    i_ioxs_master.xfer({dev_addr, 1'b0}, 1'b1, q, a);
    check("address ack", 1'b0, a);
    i_ioxs_master.xfer(cmd, 1'b1, q, a);
    check("command ack", 1'b0, a);
    foreach (d[i]) begin
      i_ioxs_master.xfer(d[i], 1'b1, q, a);
      check("data ack", 1'b0, a);
    end
    i_ioxs_master.stop();
  endtask : wr

  task automatic rd(input logic [7:0] cmd, input logic [7:0] e[$], input string what);
    logic [7:0] q;
    logic a;
    i_ioxs_master.start();
    i_ioxs_master.xfer({dev_addr, 1'b0}, 1'b1, q, a);
    i_ioxs_master.xfer(cmd, 1'b1, q, a);
    i_ioxs_master.start();
    i_ioxs_master.xfer({dev_addr, 1'b1}, 1'b1, q, a);
    check("read address ack", 1'b0, a);
    foreach (e[i]) begin
      i_ioxs_master.xfer(8'hff, i == e.size() - 1, q, a);
      check(what, e[i], q);
    end
    i_ioxs_master.stop();
    repeat (8) @(posedge clk);
  endtask : rd

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    check("reset io_out", 40'h0, io_out);
    check("reset io_oe", 40'h0, io_oe);
    check("reset irq", 1'b0, irq_oe);
    check("reset sda", 1'b0, sda_oe);
    $display("test reset done");
  endtask : t_reset

  task automatic t_write();
    wr(8'h88, '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55});
    wr(8'h18, '{8'h00});
    wr(8'h8c, '{8'h66, 8'h77});
    repeat (8) @(posedge clk);
    check("outputs", 40'h6644332277, io_out);
    check("drivers", 40'h00000000ff, io_oe);
    check("data line level", 1'b0, sda_out);
    $display("test write done");
  endtask : t_write

  task automatic t_read();
    rd(8'h8b, '{8'h44, 8'h66, 8'h77}, "read with wrap");
    rd(8'h0a, '{8'h33, 8'h33, 8'h33}, "read fixed");
    $display("test read done");
  endtask : t_read

  task automatic t_bad_addr();
    logic [7:0] q;
    logic a;
    i_ioxs_master.start();
    i_ioxs_master.xfer({SLAVE_BASE ^ 4'h1, strap, 1'b0}, 1'b1, q, a);
    check("foreign address ack", 1'b1, a);
    i_ioxs_master.xfer(8'h88, 1'b1, q, a);
    check("ignored byte ack", 1'b1, a);
    i_ioxs_master.stop();
    $display("test foreign address done");
  endtask : t_bad_addr

  task automatic t_irq();
    wr(8'ha0, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
    @(posedge clk) #1;
    io_in[20] = 1'b1;
    io_in[39] = 1'b1;
    repeat (10) @(posedge clk);
    check("irq on change", 1'b1, irq_oe);
    check("irq pin level", 1'b0, irq_out);
    rd(8'h80, '{8'h00, 8'h00, 8'h10}, "input banks 0 to 2");
    check("irq after bank 2", 1'b1, irq_oe);
    rd(8'h83, '{8'h00, 8'h80}, "input banks 3 to 4");
    check("irq after bank 4", 1'b0, irq_oe);
    @(posedge clk) #1;
    io_in[9] = 1'b1;
    repeat (10) @(posedge clk);
    check("irq on bank 1", 1'b1, irq_oe);
    #1 io_in[9] = 1'b0;
    repeat (10) @(posedge clk);
    check("irq on return", 1'b0, irq_oe);
    $display("test interrupt done");
  endtask : t_irq

  task automatic t_timeout();
    logic [7:0] q;
    logic a;
    for (int en = 0; en < 2; en++) begin
      timeout_en = en[0];
      i_ioxs_master.start();
      i_ioxs_master.xfer({dev_addr, 1'b0}, 1'b1, q, a);
      #20000;
      i_ioxs_master.xfer(8'h0b, 1'b1, q, a);
      check("ack after held clock", en[0], a);
      i_ioxs_master.stop();
    end
    timeout_en = 1'b0;
    $display("test timeout done");
  endtask : t_timeout

  task automatic t_spike_abort();
    logic [7:0] q;
    logic a;
    i_ioxs_master.glitch = 1'b1;
    wr(8'h0b, '{8'ha5});
    i_ioxs_master.glitch = 1'b0;
    rd(8'h0b, '{8'ha5}, "bank 3 after spikes");
    i_ioxs_master.start();
    i_ioxs_master.xfer({dev_addr, 1'b0}, 1'b1, q, a);
    i_ioxs_master.xfer(8'h0b, 1'b1, q, a);
    repeat (4) i_ioxs_master.bit_io(1'b0, a);
    i_ioxs_master.stop();
    rd(8'h0b, '{8'ha5}, "bank 3 after abort");
    $display("test spike and abort done");
  endtask : t_spike_abort

  // ==========================================================
  // Run control
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report

  // Whole sequence takes about 0.8 ms of bus time
  initial begin
    #1000000;
    n_mismatch++;
    final_report();
  end

  initial begin
    n_mismatch = 0;
    checks_done = 0;
    reset = 1'b1;
    timeout_en = 1'b0;
    out_en_n = 1'b0;
    io_in = '0;
    // Held over link edges too, so both domains see it
    repeat (4) @(posedge link_clk);
    @(posedge clk) #1 reset = 1'b0;
    repeat (8) @(posedge link_clk);
    t_reset();
    t_write();
    t_read();
    t_bad_addr();
    t_irq();
    t_timeout();
    t_spike_abort();
    final_report();
  end
endmodule : test_i2c_slave_register_access
